/* pkg/ssw_pkg.sv */
// Shared constants for the supply supervisor with watchdog and reset hold.
// Assumes one 10 MHz system clock; every time is given in its own unit.
package ssw_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_NS       = 1000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 4;

  // ****************************************************************
  // Reset hold and strobe window
  // ****************************************************************
  localparam int unsigned HOLD_TIME_MS   = 200;
  localparam int unsigned WINDOW_TIME_MS = 1600;
  localparam int unsigned HOLD_TICKS     = HOLD_TIME_MS * (1000000 / TICK_NS);
  localparam int unsigned WINDOW_TICKS   = WINDOW_TIME_MS * (1000000 / TICK_NS);
  localparam int unsigned CNT_W          = 21;

  // ****************************************************************
  // Manual reset input filter
  // ****************************************************************
  localparam int unsigned BTN_GLITCH_NS     = 100;
  localparam int unsigned BTN_MIN_LOW_NS    = 1000;
  localparam int unsigned BTN_FILTER_NS     = 500;
  localparam int unsigned BTN_FILTER_CYCLES =
    (BTN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DB_W              = 3;

  // ****************************************************************
  // Input synchroniser lanes and their reset levels
  // ****************************************************************
  localparam int unsigned IN_SUPPLY_LOW = 0;
  localparam int unsigned IN_BUTTON_N   = 1;
  localparam int unsigned IN_STROBE     = 2;
  localparam int unsigned IN_FLOAT      = 3;
  localparam int unsigned IN_W          = 4;
  localparam logic [3:0]  SYNC_RST      = 4'hb;

  typedef enum logic [1:0] {
    SSW_ASSERT,
    SSW_HOLD,
    SSW_RELEASED
  } ssw_state_type;

endpackage : ssw_pkg

/* core/ssw_debounce.sv */
// Glitch filter and debouncer for the manual reset level.
// Assumes the input is already synchronised to clk_sys_in.
`timescale 1ns/1ps
`default_nettype none

module ssw_debounce (
  input  wire logic clk_sys_in,
  input  wire logic arst_n_in,
  input  wire logic level_in,
  output var  logic level_out
);

  logic [ssw_pkg::DB_W-1:0] cnt_reg;
  logic                     level_reg;
  logic                     differs;

  assign differs   = level_in != level_reg;
  assign level_out = level_reg;

  // ****************************************************************
  // Stability counter
  // ****************************************************************
  // Any return to the old level restarts the count, so bounce and short
  // dips never reach the output.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg <= '0;
    end else if (!differs) begin
      cnt_reg <= '0;
    end else if (cnt_reg != ssw_pkg::DB_W'(ssw_pkg::BTN_FILTER_CYCLES - 1)) begin
      cnt_reg <= cnt_reg + ssw_pkg::DB_W'(1);
    end else begin
      cnt_reg <= '0;
    end
  end

  // Idle level high, as with the pull-up on an open input
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_reg <= 1'b1;
    end else if (differs &&
                 cnt_reg == ssw_pkg::DB_W'(ssw_pkg::BTN_FILTER_CYCLES - 1)) begin
      level_reg <= level_in;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  filter_length_a: assert property ($changed(level_reg) |->
    $past(cnt_reg) == ssw_pkg::DB_W'(ssw_pkg::BTN_FILTER_CYCLES - 1))
    else $error("Filtered level changed before the filter time");

  // A dip that ends before the count completes must leave no trace
  short_dip_a: assert property (level_reg && !level_in &&
    cnt_reg != ssw_pkg::DB_W'(ssw_pkg::BTN_FILTER_CYCLES - 1) ##1 level_in |=> level_reg)
    else $error("Short dip reached the filtered level");

endmodule : ssw_debounce

`default_nettype wire

/* core/ssw_supervisor.sv */
// Supply supervisor: undervoltage, manual reset and watchdog drive reset.
// Assumes the comparator result and the pins arrive asynchronously.
//
// What this block does
// - Undervoltage indication asserts reset
// - Active-low and optional active-high complementary outputs
// - Hold reset after supply recovers
// - Manual reset low asserts reset
// - Reject manual reset dips near 100 ns
// - Debounce manual reset push-button
// - Unconnected manual reset reads inactive high; this block has no pull-up, so the pin needs one outside
// - Hold reset after manual reset release
// - Every strobe edge clears watchdog timer
// - Full window without strobe edge asserts reset
// - Hold reset after watchdog timeout
// - Any reset clears watchdog timer
// - Timer held clear until reset deasserts
// - Floating strobe disables the watchdog
// - Hold time 200 ms, 140 to 280
// - Strobe window 1.6 s, 1.12 to 2.40
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor #(
  parameter logic [ssw_pkg::CNT_W-1:0] HOLD_TICKS   = ssw_pkg::CNT_W'(ssw_pkg::HOLD_TICKS),
  parameter logic [ssw_pkg::CNT_W-1:0] WINDOW_TICKS = ssw_pkg::CNT_W'(ssw_pkg::WINDOW_TICKS),
  parameter bit                        HAS_HIGH_OUT = 1'b1
) (
  input  wire logic clk_sys_in,
  input  wire logic arst_n_in,
  input  wire logic supply_low_in,
  input  wire logic manual_reset_n_in,
  input  wire logic watchdog_strobe_in,
  input  wire logic watchdog_strobe_float_in,
  output var  logic reset_n_out,
  output var  logic reset_out
);

  logic [ssw_pkg::IN_W-1:0]   in_vec;
  logic [ssw_pkg::IN_W-1:0]   sync1_reg;
  logic [ssw_pkg::IN_W-1:0]   sync2_reg;
  logic                       supply_low;
  logic                       strobe;
  logic                       strobe_float;
  logic                       manual_reset_n;
  logic                       strobe_prev_reg;
  logic                       strobe_edge;
  logic [ssw_pkg::TICK_W-1:0] tick_cnt_reg;
  logic                       tick;
  logic [ssw_pkg::CNT_W-1:0]  wd_cnt_reg;
  logic                       wd_expired;
  logic [ssw_pkg::CNT_W-1:0]  hold_cnt_reg;
  logic                       hold_done;
  logic                       cause;
  logic                       reset_n_reg;
  logic                       reset_reg;
  ssw_pkg::ssw_state_type     state_reg;
  ssw_pkg::ssw_state_type     state_next;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  assign in_vec[ssw_pkg::IN_SUPPLY_LOW] = supply_low_in;
  assign in_vec[ssw_pkg::IN_BUTTON_N]   = manual_reset_n_in;
  assign in_vec[ssw_pkg::IN_STROBE]     = watchdog_strobe_in;
  assign in_vec[ssw_pkg::IN_FLOAT]      = watchdog_strobe_float_in;

  // Reset levels favour a held reset with the watchdog disabled
  for (genvar i = 0; i < ssw_pkg::IN_W; i++) begin : g_sync
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        sync1_reg[i] <= ssw_pkg::SYNC_RST[i];
        sync2_reg[i] <= ssw_pkg::SYNC_RST[i];
      end else begin
        sync1_reg[i] <= in_vec[i];
        sync2_reg[i] <= sync1_reg[i];
      end
    end
  end

  assign supply_low   = sync2_reg[ssw_pkg::IN_SUPPLY_LOW];
  assign strobe       = sync2_reg[ssw_pkg::IN_STROBE];
  assign strobe_float = sync2_reg[ssw_pkg::IN_FLOAT];

  // ****************************************************************
  // Manual reset filter
  // ****************************************************************
  ssw_debounce u_button_debounce (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .level_in   (sync2_reg[ssw_pkg::IN_BUTTON_N]),
    .level_out  (manual_reset_n)
  );

  // ****************************************************************
  // Time base
  // ****************************************************************
  // Hold and window counters advance once per microsecond tick, which
  // keeps them narrow; resolution of one tick is far inside tolerance.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + ssw_pkg::TICK_W'(1);
    end
  end

  assign tick = tick_cnt_reg == ssw_pkg::TICK_W'(ssw_pkg::TICK_CYCLES - 1);

  tick_period_a: assert property (tick |=> !tick [*8] ##1 !tick ##1 tick)
    else $error("Time base tick is not every ten cycles");

  // ****************************************************************
  // Watchdog strobe edge detection
  // ****************************************************************
  // Strobe pulses shorter than one clock period can be missed; the
  // input must hold each level at least one cycle to be seen.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_prev_reg <= ssw_pkg::SYNC_RST[ssw_pkg::IN_STROBE];
    end else begin
      strobe_prev_reg <= strobe;
    end
  end

  assign strobe_edge = strobe != strobe_prev_reg;

  // ****************************************************************
  // Watchdog timer
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wd_cnt_reg <= '0;
    end else if (state_reg != ssw_pkg::SSW_RELEASED) begin
      wd_cnt_reg <= '0;
    end else if (strobe_edge || strobe_float) begin
      wd_cnt_reg <= '0;
    end else if (tick) begin
      if (wd_cnt_reg == WINDOW_TICKS - ssw_pkg::CNT_W'(1)) begin
        wd_cnt_reg <= '0;
      end else begin
        wd_cnt_reg <= wd_cnt_reg + ssw_pkg::CNT_W'(1);
      end
    end
  end

  // A floating strobe never times out
  assign wd_expired = tick && !strobe_edge && !strobe_float &&
                      state_reg == ssw_pkg::SSW_RELEASED &&
                      wd_cnt_reg == WINDOW_TICKS - ssw_pkg::CNT_W'(1);

  sequence wd_serviced_seq;
    strobe_edge && state_reg == ssw_pkg::SSW_RELEASED;
  endsequence

  sequence wd_cleared_seq;
    wd_cnt_reg == '0;
  endsequence

  strobe_clear_a: assert property (wd_serviced_seq |=> wd_cleared_seq)
    else $error("Strobe edge did not clear the watchdog timer");

  reset_clear_a: assert property (state_reg != ssw_pkg::SSW_RELEASED |=>
    wd_cleared_seq)
    else $error("Watchdog timer ran while reset was asserted");

  float_disable_a: assert property (strobe_float |-> !wd_expired)
    else $error("Floating strobe produced a watchdog timeout");

  // ****************************************************************
  // Reset causes and hold state machine
  // ****************************************************************
  // Watchdog cause is a single-cycle pulse; the state machine turns it
  // into a full hold period on its own.
  assign cause = supply_low || !manual_reset_n || wd_expired;

  assign hold_done = tick && hold_cnt_reg == HOLD_TICKS - ssw_pkg::CNT_W'(1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ssw_pkg::SSW_ASSERT: begin
        if (!cause) begin
          state_next = ssw_pkg::SSW_HOLD;
        end
      end
      ssw_pkg::SSW_HOLD: begin
        if (cause) begin
          state_next = ssw_pkg::SSW_ASSERT;
        end else if (hold_done) begin
          state_next = ssw_pkg::SSW_RELEASED;
        end
      end
      ssw_pkg::SSW_RELEASED: begin
        if (cause) begin
          state_next = ssw_pkg::SSW_ASSERT;
        end
      end
      default: begin
        state_next = ssw_pkg::SSW_ASSERT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= ssw_pkg::SSW_ASSERT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Hold counter restarts from zero whenever any cause reappears
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_cnt_reg <= '0;
    end else if (cause || state_reg != ssw_pkg::SSW_HOLD) begin
      hold_cnt_reg <= '0;
    end else if (tick) begin
      hold_cnt_reg <= hold_cnt_reg + ssw_pkg::CNT_W'(1);
    end
  end

  // ****************************************************************
  // Reset outputs
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reset_n_reg <= 1'b0;
      reset_reg   <= HAS_HIGH_OUT;
    end else begin
      reset_n_reg <= state_next == ssw_pkg::SSW_RELEASED;
      reset_reg   <= HAS_HIGH_OUT && state_next != ssw_pkg::SSW_RELEASED;
    end
  end

  assign reset_n_out = reset_n_reg;
  assign reset_out   = reset_reg;

  undervolt_reset_a: assert property (supply_low |=> !reset_n_out)
    else $error("Undervoltage did not assert reset");

  manual_reset_a: assert property (!manual_reset_n |=> !reset_n_out)
    else $error("Manual reset low did not assert reset");

  timeout_reset_a: assert property (wd_expired |=> !reset_n_out [*3])
    else $error("Watchdog timeout did not assert reset");

  complement_out_a: assert property (HAS_HIGH_OUT |-> reset_out == !reset_n_out)
    else $error("Reset outputs are not complementary");

  single_out_a: assert property (!HAS_HIGH_OUT |-> !reset_out)
    else $error("Active-high output driven on a single-output variant");

  sequence hold_expired_seq;
    state_reg == ssw_pkg::SSW_HOLD && !cause && hold_done;
  endsequence

  hold_release_a: assert property ($rose(reset_n_out) |->
    $past(hold_cnt_reg) == HOLD_TICKS - ssw_pkg::CNT_W'(1) && $past(tick))
    else $error("Reset released before the full hold time");

  release_step_a: assert property (hold_expired_seq |=> reset_n_out)
    else $error("Reset not released after the hold time");

  hold_restart_a: assert property (cause |=> hold_cnt_reg == '0 && !reset_n_out)
    else $error("Hold counter did not restart on a reset cause");

endmodule : ssw_supervisor

`default_nettype wire

/* tb/ssw_cpu_model.sv */
// Processor model: services the watchdog strobe, obeys the reset it receives.
// Assumes it shares clk_sys_in with the supervisor; it changes only on rising edges.
`timescale 1ns/1ps
`default_nettype none

module ssw_cpu_model (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic        service_in,
  input  wire logic        pulse_in,
  input  wire logic        release_in,
  input  wire logic [15:0] period_in,
  output var  logic        strobe_out,
  output var  logic        float_out
);
  logic [15:0] gap_reg   = 16'h0000;
  logic        level_reg = 1'b0;

  // ****************************************************************
  // Strobe service
  // ****************************************************************
  // A program held in reset runs no code, so it cannot strobe
  always @(posedge clk_sys_in) begin
    if (!reset_n_in || !service_in || release_in) begin
      gap_reg <= 16'h0000;
    end else if (gap_reg >= period_in) begin
      gap_reg   <= 16'h0000;
      level_reg <= ~level_reg;
    end else begin
      gap_reg <= gap_reg + 16'h0001;
      if (pulse_in && level_reg) begin
        level_reg <= 1'b0;
      end
    end
  end

  // Released driver: line sits at the inverse of its last level
  assign strobe_out = release_in ? ~level_reg : level_reg;
  assign float_out  = release_in;
endmodule : ssw_cpu_model

`default_nettype wire

/* tb/ssw_supervisor_test.sv */
// Self-checking bench: supply, manual reset and watchdog causes with hold timing.
// Assumes short HOLD_TICKS and WINDOW_TICKS; manual reset pin has a pull-up.
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor_test;
  localparam int HOLD = 20;
  localparam int WIN  = 50;
  localparam int TCK  = ssw_pkg::TICK_CYCLES;

  logic        clk_sys, arst_n, supply_low, btn_drv, btn_en;
  logic        service, pulse, rel;
  logic        prev_n = 1'b0;
  logic [15:0] period;
  logic [31:0] rng;
  tri1         btn_n_w;
  wire logic   strobe, flt, rst_n, rst;
  int          n_fail, n_compared, seen, f0;
  int          falls = 0;

  // Pull-up keeps an undriven button pin inactive
  assign btn_n_w = btn_en ? btn_drv : 1'bz;

  ssw_supervisor #(.HOLD_TICKS(21'(HOLD)), .WINDOW_TICKS(21'(WIN)), .HAS_HIGH_OUT(1'b1))
  u_ssw_supervisor (.clk_sys_in(clk_sys), .arst_n_in(arst_n), .supply_low_in(supply_low),
    .manual_reset_n_in(btn_n_w), .watchdog_strobe_in(strobe),
    .watchdog_strobe_float_in(flt), .reset_n_out(rst_n), .reset_out(rst));

  ssw_cpu_model u_ssw_cpu_model (.clk_sys_in(clk_sys), .reset_n_in(rst_n),
    .service_in(service), .pulse_in(pulse), .release_in(rel), .period_in(period),
    .strobe_out(strobe), .float_out(flt));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic int rnd(input int m);
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return int'(rng % m);
  endfunction : rnd

  function automatic int hold_lo();
    return HOLD * TCK - TCK;
  endfunction : hold_lo

  // Slack covers sync, filter and tick phase
  function automatic int hold_hi();
    return HOLD * TCK + TCK + 14;
  endfunction : hold_hi

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask : step

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_rng(input string what, input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_rng

  task automatic wait_lvl(input logic lvl, input int lim, output int n);
    n = 0;
    while (rst_n !== lvl && n < lim) begin
      step(1);
      n++;
    end
  endtask : wait_lvl

  task automatic cause_supply();
    supply_low = 1'b1;
    step(3 + rnd(5));
    supply_low = 1'b0;
  endtask : cause_supply

  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // ****************************************************************
  // Clock, monitors, watchdog
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Unknown active-low level must not pass as a match
  always @(negedge clk_sys) check_bit("reset_out", rst_n === 1'b0, rst);

  always @(negedge clk_sys) begin
    if (prev_n === 1'b1 && rst_n === 1'b0) falls++;
    prev_n <= rst_n;
  end

  initial begin
    #(100 * 40000);
    n_fail++;
    complete_run();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    arst_n = 1'b0; supply_low = 1'b0; btn_drv = 1'b1; btn_en = 1'b0;
    service = 1'b1; pulse = 1'b0; rel = 1'b0; period = 16'h0190;
    rng = 32'h0000243c; n_fail = 0; n_compared = 0;
    step(3);
    arst_n = 1'b1;
    wait_lvl(1'b1, 400, seen);
    check_rng("power-up hold", seen, hold_lo() - 4, hold_hi());
    for (int i = 0; i < 4; i++) begin
      supply_low = 1'b1;
      step(4);
      check_bit("supply reset", 1'b0, rst_n);
      step(1 + rnd(40));
      supply_low = 1'b0;
      if (i[0]) begin
        step(100);
        cause_supply();
      end
      wait_lvl(1'b1, 400, seen);
      check_rng("supply hold", seen, hold_lo(), hold_hi());
    end
    btn_en = 1'b1;
    for (int i = 0; i < 6; i++) begin
      btn_drv = 1'b0;
      step(1 + rnd(3));
      btn_drv = 1'b1;
      step(12);
      check_bit("short dip", 1'b1, rst_n);
    end
    btn_en = 1'b0;
    step(20);
    check_bit("open button", 1'b1, rst_n);
    f0 = falls;
    btn_en = 1'b1;
    repeat (4) begin
      btn_drv = 1'b0;
      step(1 + rnd(3));
      btn_drv = 1'b1;
      step(1 + rnd(3));
    end
    btn_drv = 1'b0;
    step(12);
    check_bit("button reset", 1'b0, rst_n);
    step(8);
    btn_drv = 1'b1;
    step(2);
    btn_drv = 1'b0;
    step(2);
    btn_en = 1'b0;
    wait_lvl(1'b1, 400, seen);
    check_rng("button hold", seen, hold_lo(), hold_hi());
    check_rng("reset pulses", falls - f0, 1, 1);
    f0 = falls;
    for (int i = 0; i < 4; i++) begin
      period = 16'(100 + rnd(340));
      pulse = rng[3];
      step(1500);
    end
    check_rng("serviced resets", falls - f0, 0, 0);
    service = 1'b0;
    cause_supply();
    wait_lvl(1'b1, 400, seen);
    check_rng("short supply hold", seen, hold_lo(), hold_hi());
    step(300);
    cause_supply();
    wait_lvl(1'b1, 400, seen);
    check_rng("hold before window", seen, hold_lo(), hold_hi());
    wait_lvl(1'b0, 700, seen);
    check_rng("window", seen, WIN * TCK - TCK, WIN * TCK + TCK + 4);
    wait_lvl(1'b1, 400, seen);
    check_rng("timeout hold", seen, hold_lo(), hold_hi());
    rel = 1'b1;
    f0 = falls;
    step(1500);
    check_rng("floating resets", falls - f0, 0, 0);
    rel = 1'b0;
    wait_lvl(1'b0, 700, seen);
    check_rng("window after float", seen, WIN * TCK - TCK, WIN * TCK + TCK + 4);
    complete_run();
  end
endmodule : ssw_supervisor_test

`default_nettype wire
